// ==== hdl/hvsp_pkg.sv ====
// constants, types and timing for the high-voltage serial programming port
package hvsp_pkg;
    // clock and link timing
    localparam int CLK_PERIOD_NS      = 40;
    localparam int PCLK_MIN_PERIOD_NS = 220;
    localparam int HV_LATCH_HOLD_NS   = 100;
    localparam int HV_LATCH_CYCLES    = (HV_LATCH_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_ERASE_NS         = 4_000_000;
    localparam int T_FLASH_NS         = 4_500_000;
    localparam int T_EEPROM_NS        = 4_000_000;
    localparam int ERASE_CYCLES_DOC   = T_ERASE_NS / CLK_PERIOD_NS;
    localparam int FLASH_CYCLES_DOC   = T_FLASH_NS / CLK_PERIOD_NS;
    localparam int EEPROM_CYCLES_DOC  = T_EEPROM_NS / CLK_PERIOD_NS;

    // frame layout: leading zero, eight payload bits msb first, two trailing zeros
    localparam int FRAME_BITS   = 11;
    localparam int PAYLOAD_MSB  = 9;
    localparam int PAYLOAD_LSB  = 2;

    // entry pattern on the selection pins
    localparam logic [2:0] PROG_ENABLE_PATTERN = 3'h0;

    // serial instruction codes
    localparam logic [7:0] INS_CMD_LOAD   = 8'h4C;
    localparam logic [7:0] INS_ADDR_LOW   = 8'h0C;
    localparam logic [7:0] INS_ADDR_HIGH  = 8'h1C;
    localparam logic [7:0] INS_DATA_LOW   = 8'h2C;
    localparam logic [7:0] INS_DATA_HIGH  = 8'h3C;
    localparam logic [7:0] INS_PAGE_LATCH = 8'h6D;
    localparam logic [7:0] INS_WR_ARM     = 8'h64;
    localparam logic [7:0] INS_WR_FIRE    = 8'h6C;
    localparam logic [7:0] INS_RD_LOW     = 8'h68;
    localparam logic [7:0] INS_RD_HIGH    = 8'h78;

    // command codes carried on serial data with the command-load pattern
    localparam logic [7:0] CMD_NOP          = 8'h00;
    localparam logic [7:0] CMD_CHIP_ERASE   = 8'h80;
    localparam logic [7:0] CMD_WRITE_FLASH  = 8'h10;
    localparam logic [7:0] CMD_READ_FLASH   = 8'h02;
    localparam logic [7:0] CMD_WRITE_EEPROM = 8'h11;
    localparam logic [7:0] CMD_READ_EEPROM  = 8'h03;

    // memory geometry and erased values
    localparam int          FLASH_WORDS   = 2048;
    localparam int          FLASH_PAGE    = 32;
    localparam int          EEPROM_BYTES  = 256;
    localparam int          EEPROM_PAGE   = 4;
    localparam logic [15:0] ERASED_WORD   = 16'hFFFF;
    localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
    localparam logic [7:0]  LOCK_RESET    = 8'hFF;
    localparam logic [7:0]  FUSE_HIGH_RESET = 8'hDF;
    localparam int          EEPROM_KEEP_BIT = 6;

    // one captured frame
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] instr;
    } hvsp_frame_s;

    typedef enum logic [2:0] {
        ST_OFF      = 3'h0,
        ST_LATCH    = 3'h1,
        ST_ACTIVE   = 3'h2,
        ST_ER_FLASH = 3'h3,
        ST_ER_EEP   = 3'h4,
        ST_PG_FLASH = 3'h5,
        ST_PG_EEP   = 3'h6,
        ST_WAIT     = 3'h7
    } hvsp_state_e;
endpackage

// ==== hdl/hvsp_link_rx.sv ====
// link-clock side: frame shifter and read-back bit sequencer
`timescale 1ns/1ns
module hvsp_link_rx
    import hvsp_pkg::*;
(
    input  wire logic        i_prog_clk,
    input  wire logic        i_active,
    input  wire logic        i_serial_data_in,
    input  wire logic        i_serial_instr_in,
    input  wire logic [7:0]  i_read_byte,
    output hvsp_frame_s      o_frame,
    output logic             o_frame_toggle,
    output logic             o_out_bit
);
    logic              act_meta;
    logic              act_sync;
    logic [3:0]        bit_cnt;
    logic [10:0]       sh_data;
    logic [10:0]       sh_instr;

    // mode level from the core domain, two flip-flops
    always_ff @(posedge i_prog_clk) begin
        act_meta <= i_active;
        act_sync <= act_meta;
    end

    // shift both lines in parallel, msb first, one bit per rising edge
    always_ff @(posedge i_prog_clk) begin
        if (!act_sync) begin
            bit_cnt  <= 4'h0;
            sh_data  <= 11'h000;
            sh_instr <= 11'h000;
        end else begin
            sh_data  <= {sh_data[9:0], i_serial_data_in};    // R2 R27
            sh_instr <= {sh_instr[9:0], i_serial_instr_in};  // R27
            if (bit_cnt == 4'(FRAME_BITS - 1)) begin
                bit_cnt <= 4'h0;
            end else begin
                bit_cnt <= bit_cnt + 4'h1;
            end
        end
    end

    // hand a finished frame to the core: word held, toggle marks it
    always_ff @(posedge i_prog_clk) begin
        if (!act_sync) begin
            o_frame        <= '0;
            o_frame_toggle <= 1'b0;
        end else if (bit_cnt == 4'(FRAME_BITS - 1)) begin
            // ten bits are in: payload sits at 8..1, the last trailing zero is dropped
            o_frame.data   <= sh_data[PAYLOAD_MSB-1:PAYLOAD_LSB-1];   // R22
            o_frame.instr  <= sh_instr[PAYLOAD_MSB-1:PAYLOAD_LSB-1];
            o_frame_toggle <= ~o_frame_toggle;
        end
    end

    // read-back bit for positions 0..7 of each frame; byte is stable between frames
    always_ff @(posedge i_prog_clk) begin
        if (!act_sync || bit_cnt > 4'h7) begin
            o_out_bit <= 1'b0;
        end else begin
            o_out_bit <= i_read_byte[3'(4'h7 - bit_cnt)];  // R20 R21
        end
    end
endmodule // hvsp_link_rx

// ==== hdl/hvsp_port.sv ====
// high-voltage serial programming port: entry, command decode, memories, page program
// Function
// R1: four serial lines, clock period at least 220ns
// R2: bits sampled on programming clock rising edge
// R3: programmer toggles clock six times beforehand
// R4: selection pins 000, wait 100ns, then HV
// R5: selection latched under HV, held 100ns
// R6: device drives data-out after latch hold
// R7: programmer waits 50us before first frame
// R8: command and address kept across accesses
// R9: programmer loads command once per series
// R10: programmer may skip writing erased 0xFF
// R11: upper address reloaded only per 256 window
// R12: erase clears flash, EEPROM, then lock bits; code clears lock bits after flash, before EEPROM
// R13: erase leaves all fuse bits unchanged
// R14: keep fuse set: EEPROM survives erase
// R15: programmer erases before reprogramming memories
// R16: erase: third frame, wait data-out high
// R17: data collected in page buffer first
// R18: flash page program, wait after frame three
// R19: EEPROM page program, wait after frame two
// R20: read-flash shifts out low, high bytes
// R21: read-EEPROM shifts out the addressed byte
// R22: frame is 0, eight payload bits, 00
// R23: write-flash command code 0001_0000
// R24: read-flash command code 0000_0010
// R25: programmer exits clock low, reset high
// R26: data-out low while busy, high when done
// R27: lines shifted together, eleven clocks per frame
`timescale 1ns/1ns
module hvsp_port
    import hvsp_pkg::*;
#(
    parameter int P_ERASE_CYCLES  = ERASE_CYCLES_DOC,
    parameter int P_FLASH_CYCLES  = FLASH_CYCLES_DOC,
    parameter int P_EEPROM_CYCLES = EEPROM_CYCLES_DOC,
    parameter int P_FLASH_WORDS   = FLASH_WORDS,
    parameter int P_FLASH_PAGE    = FLASH_PAGE,
    parameter int P_EEPROM_BYTES  = EEPROM_BYTES,
    parameter int P_EEPROM_PAGE   = EEPROM_PAGE
) (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_clk_en,
    input  wire logic        i_prog_clk,
    input  wire logic        i_hv_reset_level,
    input  wire logic [2:0]  i_prog_enable,
    input  wire logic        i_serial_data_in,
    input  wire logic        i_serial_instr_in,
    output logic             o_serial_data_out,
    output logic             o_serial_data_out_oe,
    output logic             o_prog_mode,
    output logic             o_busy,
    output logic [7:0]       o_lock_bits
);
    localparam int FAW = $clog2(P_FLASH_WORDS);
    localparam int PAW = $clog2(P_FLASH_PAGE);
    localparam int EAW = $clog2(P_EEPROM_BYTES);
    localparam int EPW = $clog2(P_EEPROM_PAGE);

    // elaboration check: refuse sizes the address logic cannot serve
    if (FAW > 16 || FAW <= PAW || EAW > 8 || EAW <= EPW ||
        P_ERASE_CYCLES < 1 || P_FLASH_CYCLES < 1 || P_EEPROM_CYCLES < 1 ||
        P_FLASH_WORDS < P_EEPROM_BYTES) begin : g_bad_params
        $error("hvsp_port: unsupported parameter values");
    end

    // full flash word address from the two address bytes
    function automatic logic [FAW-1:0] flash_addr(input logic [7:0] hi, input logic [7:0] lo);
        logic [15:0] full;
        full = {hi, lo};
        return full[FAW-1:0];
    endfunction

    // sync chains, first stage read only by second stage
    logic [2:0]        pe_meta;
    logic [2:0]        pe_sync;
    logic              hv_meta;
    logic              hv_sync;
    logic              tog_meta;
    logic              tog_sync;
    logic              tog_seen;
    logic              bit_meta;
    logic              bit_sync;

    hvsp_state_e       state;
    logic [31:0]       timer;
    logic [FAW-1:0]    walk;
    logic              armed;
    logic              readout;
    logic [7:0]        cmd;
    logic [7:0]        addr_low;
    logic [7:0]        addr_high;
    logic [7:0]        data_low;
    logic [7:0]        data_high;
    logic [7:0]        read_byte;
    logic [7:0]        lock_bits;
    logic [7:0]        fuse_high;
    logic              link_active;
    hvsp_frame_s       frame;
    logic              frame_toggle;
    logic              out_bit;
    logic              new_frame;
    logic [FAW-1:0]    prog_base;

    logic [15:0]       flash_mem [P_FLASH_WORDS];
    logic [7:0]        eep_mem   [P_EEPROM_BYTES];
    logic [15:0]       fpage     [P_FLASH_PAGE];
    logic [7:0]        epage     [P_EEPROM_PAGE];
    logic [P_EEPROM_PAGE-1:0] epage_valid;

    hvsp_link_rx u_link (
        .i_prog_clk        (i_prog_clk),  // R1
        .i_active          (link_active),
        .i_serial_data_in  (i_serial_data_in),
        .i_serial_instr_in (i_serial_instr_in),
        .i_read_byte       (read_byte),
        .o_frame           (frame),
        .o_frame_toggle    (frame_toggle),
        .o_out_bit         (out_bit)
    );

    // pins, frame toggle and read-back bit enter the core through two flip-flops; the frame word is used unsynchronised
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pe_meta  <= 3'h0;
            pe_sync  <= 3'h0;
            hv_meta  <= 1'b0;
            hv_sync  <= 1'b0;
            tog_meta <= 1'b0;
            tog_sync <= 1'b0;
            tog_seen <= 1'b0;
            bit_meta <= 1'b0;
            bit_sync <= 1'b0;
        end else if (i_clk_en) begin
            pe_meta  <= i_prog_enable;
            pe_sync  <= pe_meta;
            hv_meta  <= i_hv_reset_level;
            hv_sync  <= hv_meta;
            tog_meta <= frame_toggle;
            tog_sync <= tog_meta;
            tog_seen <= tog_sync;
            bit_meta <= out_bit;
            bit_sync <= bit_meta;
        end
    end

    assign new_frame = i_clk_en && (tog_sync != tog_seen) && (state == ST_ACTIVE);
    assign prog_base = flash_addr(addr_high, addr_low);  // page base for programming

    // entry, operations and their busy time
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state       <= ST_OFF;
            timer       <= 32'h0000_0000;
            walk        <= '0;
            link_active <= 1'b0;
            lock_bits   <= LOCK_RESET;
        end else if (i_clk_en) begin
            case (state)
                ST_OFF: begin
                    link_active <= 1'b0;
                    timer       <= 32'h0000_0000;
                    if (hv_sync && pe_sync == PROG_ENABLE_PATTERN) begin  // R4 R5
                        state <= ST_LATCH;
                    end
                end
                ST_LATCH: begin
                    // pattern must stay put for the whole hold time
                    if (!hv_sync || pe_sync != PROG_ENABLE_PATTERN) begin  // R5
                        state <= ST_OFF;
                    end else if (timer == 32'(HV_LATCH_CYCLES - 1)) begin
                        state       <= ST_ACTIVE;                        // R6
                        link_active <= 1'b1;
                        timer       <= 32'h0000_0000;
                    end else begin
                        timer <= timer + 32'h0000_0001;
                    end
                end
                ST_ACTIVE: begin
                    walk <= '0;
                    if (new_frame && frame.instr == INS_WR_FIRE && armed) begin
                        if (cmd == CMD_CHIP_ERASE) begin
                            state <= ST_ER_FLASH;                        // R16
                        end else if (cmd == CMD_WRITE_FLASH) begin
                            state <= ST_PG_FLASH;                        // R18
                        end else if (cmd == CMD_WRITE_EEPROM) begin
                            state <= ST_PG_EEP;                          // R19
                        end
                    end
                end
                ST_ER_FLASH: begin
                    walk <= walk + 1'b1;
                    if (walk == FAW'(P_FLASH_WORDS - 1)) begin
                        // lock bits open on the same edge that blanks the last flash word
                        lock_bits <= LOCK_RESET;                         // R12
                        walk      <= '0;
                        state     <= fuse_high[EEPROM_KEEP_BIT] ? ST_ER_EEP : ST_WAIT;  // R14
                        timer     <= 32'(P_ERASE_CYCLES);
                    end
                end
                ST_ER_EEP: begin
                    walk <= walk + 1'b1;
                    if (walk == FAW'(P_EEPROM_BYTES - 1)) begin
                        state <= ST_WAIT;
                    end
                end
                ST_PG_FLASH: begin
                    walk <= walk + 1'b1;
                    if (walk == FAW'(P_FLASH_PAGE - 1)) begin
                        state <= ST_WAIT;
                        timer <= 32'(P_FLASH_CYCLES);
                    end
                end
                ST_PG_EEP: begin
                    walk <= walk + 1'b1;
                    if (walk == FAW'(P_EEPROM_PAGE - 1)) begin
                        state <= ST_WAIT;
                        timer <= 32'(P_EEPROM_CYCLES);
                    end
                end
                ST_WAIT: begin
                    if (timer <= 32'h0000_0001) begin
                        state <= ST_ACTIVE;                              // R26
                    end else begin
                        timer <= timer - 32'h0000_0001;
                    end
                end
                default: begin
                    state <= ST_OFF;
                end
            endcase
            // dropping the high voltage ends the session at any point
            if (!hv_sync && state != ST_OFF) begin
                state       <= ST_OFF;
                link_active <= 1'b0;
            end
        end
    end

    // command, address and data latches; kept until overwritten
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cmd       <= CMD_NOP;
            addr_low  <= 8'h00;
            addr_high <= 8'h00;
            data_low  <= 8'h00;
            data_high <= 8'h00;
            armed     <= 1'b0;
        end else if (new_frame) begin
            armed <= (frame.instr == INS_WR_ARM);
            case (frame.instr)
                INS_CMD_LOAD:  cmd       <= frame.data;   // R8 R23 R24
                INS_ADDR_LOW:  addr_low  <= frame.data;   // R8
                INS_ADDR_HIGH: addr_high <= frame.data;
                INS_DATA_LOW:  data_low  <= frame.data;
                INS_DATA_HIGH: data_high <= frame.data;
                default: begin
                end
            endcase
        end
    end

    // page buffers collect data until a page program
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            epage_valid <= '0;
            // blank buffer, so unloaded words of the first page program as erased
            for (int i = 0; i < P_FLASH_PAGE; i++) begin
                fpage[i] <= ERASED_WORD;
            end
        end else if (i_clk_en) begin
            if (new_frame && frame.instr == INS_PAGE_LATCH) begin
                if (cmd == CMD_WRITE_FLASH) begin
                    fpage[addr_low[PAW-1:0]] <= {data_high, data_low};   // R17
                end else if (cmd == CMD_WRITE_EEPROM) begin
                    epage[addr_low[EPW-1:0]]       <= data_low;          // R17
                    epage_valid[addr_low[EPW-1:0]] <= 1'b1;
                end
            end else if (state == ST_PG_FLASH) begin
                fpage[walk[PAW-1:0]] <= ERASED_WORD;
            end else if (state == ST_PG_EEP) begin
                epage_valid[walk[EPW-1:0]] <= 1'b0;
            end
        end
    end

    // memory arrays: erase walks and page copies
    always_ff @(posedge i_clk) begin
        if (i_clk_en) begin
            case (state)
                ST_ER_FLASH: begin
                    flash_mem[walk] <= ERASED_WORD;                     // R12
                end
                ST_ER_EEP: begin
                    eep_mem[walk[EAW-1:0]] <= ERASED_BYTE;              // R12
                end
                ST_PG_FLASH: begin
                    flash_mem[{prog_base[FAW-1:PAW], walk[PAW-1:0]}] <= fpage[walk[PAW-1:0]];  // R18
                end
                ST_PG_EEP: begin
                    if (epage_valid[walk[EPW-1:0]]) begin
                        eep_mem[{addr_low[EAW-1:EPW], walk[EPW-1:0]}]
                            <= epage[walk[EPW-1:0]];                    // R19
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // fuses hold their value through every operation
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            fuse_high <= FUSE_HIGH_RESET;                                // R13
        end
    end

    // read byte staging and read-back window
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            read_byte <= 8'h00;
            readout   <= 1'b0;
        end else if (new_frame) begin
            readout <= 1'b0;
            if (frame.instr == INS_RD_LOW && cmd == CMD_READ_FLASH) begin
                read_byte <= flash_mem[flash_addr(addr_high, addr_low)][7:0];   // R20
                readout   <= 1'b1;
            end else if (frame.instr == INS_RD_HIGH && cmd == CMD_READ_FLASH) begin
                read_byte <= flash_mem[flash_addr(addr_high, addr_low)][15:8];  // R20
                readout   <= 1'b1;
            end else if (frame.instr == INS_RD_LOW && cmd == CMD_READ_EEPROM) begin
                read_byte <= eep_mem[addr_low[EAW-1:0]];                         // R21
                readout   <= 1'b1;
            end
        end
    end

    // pin drivers and status outputs, all registered
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_serial_data_out    <= 1'b0;
            o_serial_data_out_oe <= 1'b0;
            o_prog_mode          <= 1'b0;
            o_busy               <= 1'b0;
            o_lock_bits          <= LOCK_RESET;
        end else if (i_clk_en) begin
            o_serial_data_out_oe <= (state != ST_OFF) && (state != ST_LATCH);  // R6
            o_prog_mode          <= (state != ST_OFF) && (state != ST_LATCH);
            o_busy               <= (state >= ST_ER_FLASH);
            o_lock_bits          <= lock_bits;
            if (state >= ST_ER_FLASH) begin
                o_serial_data_out <= 1'b0;                                      // R26
            end else if (readout) begin
                o_serial_data_out <= bit_sync;
            end else begin
                o_serial_data_out <= 1'b1;                                      // R26
            end
        end
    end
endmodule // hvsp_port

// ==== verification/hvsp_port_sva.sv ====
// assertion checker for the high-voltage serial programming port
`timescale 1ns/1ns
module hvsp_port_sva (
    input wire logic       i_clk,
    input wire logic       i_reset,
    input wire logic       i_clk_en,
    input wire logic       i_prog_clk,
    input wire logic       i_hv_reset_level,
    input wire logic [2:0] i_prog_enable,
    input wire logic       i_serial_data_in,
    input wire logic       i_serial_instr_in,
    input wire logic       o_serial_data_out,
    input wire logic       o_serial_data_out_oe,
    input wire logic       o_prog_mode,
    input wire logic       o_busy,
    input wire logic [7:0] o_lock_bits
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset || !i_clk_en);
    // busy and ready as seen on data-out, minimum busy length, lock byte after an operation
    a_busy_sdo_low: assert property (o_busy |-> !o_serial_data_out)
        else $error("data-out high while busy");
    a_done_sdo_high: assert property ($fell(o_busy) && o_prog_mode |-> o_serial_data_out)
        else $error("data-out low after operation");
    a_busy_min: assert property ($rose(o_busy) |=> o_busy [*8])
        else $error("operation ended too soon");
    a_lock_after_op: assert property ($fell(o_busy) |-> o_lock_bits == 8'hFF)
        else $error("lock byte not cleared");
    // entry and exit of programming mode
    a_entry_pins: assert property ($rose(o_prog_mode) |-> $past(i_prog_enable, 4) == 3'h0)
        else $error("mode entered without entry pattern");
    a_entry_ready: assert property ($rose(o_prog_mode) |-> o_serial_data_out)
        else $error("data-out not ready on entry");
    a_oe_in_mode: assert property (o_prog_mode |-> o_serial_data_out_oe)
        else $error("data-out not driven in mode");
    a_hv_off_exit: assert property (!i_hv_reset_level [*8] |-> !o_prog_mode)
        else $error("mode kept without high voltage");
    c_entry: cover property ($rose(o_prog_mode));
    c_busy: cover property ($rose(o_busy));
    c_done: cover property ($fell(o_busy));
endmodule // hvsp_port_sva

// ==== verification/hvsp_prog_model.sv ====
// programmer model: entry sequence, serial frames and exit
`timescale 1ns/1ns
module hvsp_prog_model (
    input  wire logic       i_dout,
    input  wire logic       i_dout_oe,
    output logic            o_prog_clk,
    output logic            o_din,
    output logic            o_ins,
    output logic            o_hv,
    output wire logic [2:0] o_pins
);
    logic       pin_drv;
    logic [1:0] pin_lo;
    // shared pin: programmer drive, then device data-out, else pull-up
    assign o_pins = {pin_drv ? 1'b0 : (i_dout_oe ? i_dout : 1'b1), pin_lo};
    initial begin
        o_prog_clk = 0;
        o_din = 0;
        o_ins = 0;
        o_hv = 0;
        pin_drv = 1;
        pin_lo = 2'h3;
    end
    // entry: six clocks, pattern, high voltage, release shared pin
    task automatic enter();
        int n;
        n = 0;
        #7; // link edges stay off the core clock grid
        repeat (6) begin
            #120 o_prog_clk = 1;
            #120 o_prog_clk = 0;
        end
        pin_lo = 2'h0;
        #120 o_hv = 1;
        while (i_dout_oe !== 1'b1 && n < 100) begin
            #40 n++;
        end
        pin_drv = 0;
        #50_000;
        // two idle clocks carry the mode level through the link synchroniser
        repeat (2) begin
            #120 o_prog_clk = 1;
            #120 o_prog_clk = 0;
        end
    endtask
    // one frame, bits set on the falling edge, read-back sampled late
    task automatic frame(input logic [7:0] d, input logic [7:0] ins, output logic [7:0] q);
        logic [10:0] wd;
        logic [10:0] wi;
        wd = {1'b0, d, 2'b00};
        wi = {1'b0, ins, 2'b00};
        q = 8'h00;
        for (int i = 0; i < 11; i++) begin
            o_din = wd[10-i];
            o_ins = wi[10-i];
            #100 if (i >= 1 && i <= 8) q = {q[6:0], i_dout};
            #20 o_prog_clk = 1;
            #120 o_prog_clk = 0;
        end
        #480;
    endtask
    // exit: clock low, then reset pin back to logic level
    task automatic leave();
        o_prog_clk = 0;
        #240 o_hv = 0;
    endtask
endmodule // hvsp_prog_model

// ==== verification/tb_hvsp_port.sv ====
// self-checking testbench for the high-voltage serial programming port
`timescale 1ns/1ns
module tb_hvsp_port
    import hvsp_pkg::*;
();
    logic clk = 0, rst = 1, clk_en = 1, pclk, din, ins, hv, dout, oe, mode, busy;
    logic [2:0] pins;
    logic [7:0] lock, q;
    int err_total = 0, tests_run = 0;
    always #20 clk = ~clk;
    hvsp_prog_model PM (.i_dout(dout), .i_dout_oe(oe), .o_prog_clk(pclk), .o_din(din),
        .o_ins(ins), .o_hv(hv), .o_pins(pins));
    hvsp_port #(.P_ERASE_CYCLES(20), .P_FLASH_CYCLES(20), .P_EEPROM_CYCLES(20)) DUT (
        .i_clk(clk), .i_reset(rst), .i_clk_en(clk_en), .i_prog_clk(pclk),
        .i_hv_reset_level(hv), .i_prog_enable(pins), .i_serial_data_in(din),
        .i_serial_instr_in(ins), .o_serial_data_out(dout), .o_serial_data_out_oe(oe),
        .o_prog_mode(mode), .o_busy(busy), .o_lock_bits(lock));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic fr(input logic [7:0] d, input logic [7:0] ins);
        PM.frame(d, ins, q);
    endtask
    task automatic op_done();
        int n = 0;
        chk({7'h0, dout}, 8'h00);
        while (dout !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        chk({6'h0, busy, dout}, 8'h01);
    endtask
    task automatic rd_word(input logic [7:0] a, input logic [15:0] exp);
        fr(a, INS_ADDR_LOW);
        fr(8'h00, INS_RD_LOW);
        fr(8'h00, INS_RD_HIGH);
        chk(q, exp[7:0]);
        fr(8'h00, 8'h00);
        chk(q, exp[15:8]);
    endtask
    task automatic rd_ee(input logic [7:0] a, input logic [7:0] exp);
        fr(a, INS_ADDR_LOW);
        fr(8'h00, INS_RD_LOW);
        fr(8'h00, 8'h00);
        chk(q, exp);
    endtask
    task automatic t_entry();
        PM.enter();
        chk({5'h0, mode, oe, dout}, 8'h07);
        $display("test entry done");
    endtask
    task automatic t_erase();
        fr(CMD_CHIP_ERASE, INS_CMD_LOAD);
        fr(8'h00, INS_WR_ARM);
        fr(8'h00, INS_WR_FIRE);
        op_done();
        chk(lock, LOCK_RESET);
        fr(CMD_NOP, INS_CMD_LOAD);
        $display("test erase done");
    endtask
    task automatic t_eeprom();
        fr(CMD_WRITE_EEPROM, INS_CMD_LOAD);
        fr(8'h03, INS_ADDR_LOW);
        fr(8'hA5, INS_DATA_LOW);
        fr(8'h00, INS_PAGE_LATCH);
        fr(8'h00, INS_WR_ARM);
        fr(8'h00, INS_WR_FIRE);
        op_done();
        fr(CMD_READ_EEPROM, INS_CMD_LOAD);
        rd_ee(8'h03, 8'hA5);
        rd_ee(8'h03, 8'hA5);
        $display("test eeprom done");
    endtask
    task automatic t_flash();
        fr(CMD_WRITE_FLASH, INS_CMD_LOAD);
        fr(8'h05, INS_ADDR_LOW);
        fr(8'h34, INS_DATA_LOW);
        fr(8'h12, INS_DATA_HIGH);
        fr(8'h00, INS_PAGE_LATCH);
        fr(8'h00, INS_ADDR_HIGH);
        fr(8'h00, INS_WR_ARM);
        fr(8'h00, INS_WR_FIRE);
        op_done();
        fr(CMD_READ_FLASH, INS_CMD_LOAD);
        rd_word(8'h05, 16'h1234);
        rd_word(8'h06, ERASED_WORD);
        $display("test flash done");
    endtask
    task automatic t_keep();
        fr(CMD_READ_EEPROM, INS_CMD_LOAD);
        // an unprogrammed keep fuse (1) lets the erase clear the EEPROM
        rd_ee(8'h03, FUSE_HIGH_RESET[EEPROM_KEEP_BIT] ? ERASED_BYTE : 8'hA5);
        fr(CMD_READ_FLASH, INS_CMD_LOAD);
        rd_word(8'h05, ERASED_WORD);
        PM.leave();
        repeat (20) @(negedge clk);
        chk({6'h0, mode, oe}, 8'h00);
        $display("test keep and exit done");
    endtask
    task automatic complete_run();
        $display("tests %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #3_000_000;
        err_total++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 0;
        t_entry();
        t_erase();
        t_eeprom();
        t_flash();
        t_erase();
        t_keep();
        complete_run();
    end
endmodule // tb_hvsp_port
bind hvsp_port hvsp_port_sva chk (.i_clk(i_clk), .i_reset(i_reset), .i_clk_en(i_clk_en),
    .i_prog_clk(i_prog_clk), .i_hv_reset_level(i_hv_reset_level),
    .i_prog_enable(i_prog_enable), .i_serial_data_in(i_serial_data_in),
    .i_serial_instr_in(i_serial_instr_in), .o_serial_data_out(o_serial_data_out),
    .o_serial_data_out_oe(o_serial_data_out_oe), .o_prog_mode(o_prog_mode),
    .o_busy(o_busy), .o_lock_bits(o_lock_bits));
